/* sram_burst_pkg.sv */
/*
 * Shared constants, the controller state enum and the burst-order functions for the
 * cache SRAM memory-bus burst counter and its bus controller.
 * Assumes a 200 MHz system clock on both ends.
 */
package sram_burst_pkg;

    // burst counter geometry
    localparam int        PTR_W       = 3;
    localparam logic [2:0] MASK_FOUR  = 3'h3;
    localparam logic [2:0] MASK_EIGHT = 3'h7;
    localparam logic [2:0] ZERO_BASE  = 3'h0;
    localparam logic [2:0] PTR_RST    = 3'h0;
    localparam logic [3:0] BEATS_FOUR  = 4'h4;
    localparam logic [3:0] BEATS_EIGHT = 4'h8;

    // memory clock made by the controller from its own clock
    localparam int CLK_PERIOD_NS  = 5;
    localparam int MCLK_PERIOD_NS = 60;
    localparam logic [3:0] MCLK_HALF_CYC =
        4'(MCLK_PERIOD_NS / (2 * CLK_PERIOD_NS));
    localparam logic [3:0] DIV_RST = 4'h0;

    typedef enum logic [2:0] {
        C_INIT,
        C_IDLE,
        C_XFER,
        C_EOC
    } ctl_state_e;

    // interleaved burst order: start address xor beat index, cut to line
    function automatic logic [2:0] burst_ptr(
        input logic [2:0] start,
        input logic [2:0] idx,
        input logic       four
    );
        logic [2:0] mask;
        mask = four ? MASK_FOUR : MASK_EIGHT;
        return (start ^ idx) & mask;
    endfunction

    // next beat index, wrapping at the line length
    function automatic logic [2:0] burst_step(
        input logic [2:0] idx,
        input logic       four
    );
        logic [2:0] mask;
        mask = four ? MASK_FOUR : MASK_EIGHT;
        return 3'(idx + 3'h1) & mask;
    endfunction

endpackage

/* burst_link.sv */
/*
 * Memory-bus link between the bus controller and the cache SRAM burst
 * counter. All pins are one-way, driven by the controller.
 * Assumes the bench feeds mclk_pin to the device's mclk port.
 */
`timescale 1ns/10ps
interface burst_link;
    logic sel_n;      // buffer select, doubles as line-size strap
    logic brdy_n;     // burst ready
    logic zbt_n;      // zero-base transfer
    logic eoc_n;      // end of cycle
    logic istb;       // input strobe
    logic ostb;       // output strobe
    logic mclk_pin;   // strobed-mode select, memory clock when toggling

    modport ctl (
        output sel_n,
        output brdy_n,
        output zbt_n,
        output eoc_n,
        output istb,
        output ostb,
        output mclk_pin
    );

    modport dev (
        input sel_n,
        input brdy_n,
        input zbt_n,
        input eoc_n,
        input istb,
        input ostb,
        input mclk_pin
    );
endinterface

/* sram_burst_dev.sv */
/*
 * Cache SRAM memory-bus burst counter: tracks which word of the memory
 * cycle or writeback buffer is on the memory bus, in clocked mode (on
 * the memory clock) or strobed mode (strobes oversampled on clk).
 * Assumes a controller end on burst_link, mclk tied to the link's mclk_pin.
 */
// Behaviour
// R01 - burst ready ignored unless select active
// R02 - zero-base sampled while deselected, held when selected
// R03 - deselect initialises counter per sampled zero-base
// R04 - counter steps burst order per ready or strobe
// R05 - deselect returns counter to original burst start
// R06 - end-of-cycle also resets the counter
// R07 - controller may keep select off for singles
// R08 - controller resets counter before every transfer
// R09 - interrupted transfers: controller deasserts select
// R10 - controller holds select off one clock after reset
// R11 - clocked: select sampled each edge, off resets
// R12 - clocked: select and ready both active increments
// R13 - clocked: controller drives select valid every edge
// R14 - strobed: zero-base at select fall, strobes increment
// R15 - strobed: select rising edge resets counter
// R16 - select may assert together with ready/strobe
// R17 - static select-mode pin means strobed mode
// R18 - toggling select-mode pin means clocked mode
// R19 - line length strap sampled during reset
// R20 - strap pin becomes select after reset
// R21 - zero-base active starts transfer at address 0
// R22 - clocked: zero-base also sampled at end-of-cycle
// R23 - strap high four transfers, low eight
`timescale 1ns/10ps
module sram_burst_dev
    import sram_burst_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       mclk,
    burst_link.dev          lnk,
    input  wire logic [2:0] burst_start,
    output logic      [2:0] ptr_link,
    output logic      [2:0] ptr_strb,
    output logic            mode_clocked,
    output logic            lines_four
);

    // system-clock state: strap, mode detect, strobed counter
    typedef struct packed {
        logic [2:0] sel_p;
        logic [2:0] mode_p;
        logic [2:0] eoc_p;
        logic [1:0] zbt_p;
        logic [2:0] istb_p;
        logic [2:0] ostb_p;
        logic       four;
        logic       clocked;
        logic       zbt_lat;
        logic [2:0] idx;
        logic [2:0] ptr;
    } sys_s;

    // link-clock state: clocked-mode counter
    typedef struct packed {
        logic [1:0] rst_p;
        logic [1:0] four_p;
        logic [2:0] start_p0;
        logic [2:0] start_p1;
        logic       zbt_lat;
        logic [2:0] idx;
        logic [2:0] ptr;
    } lnk_s;

    sys_s sys_q;
    sys_s sys_d;
    lnk_s lnk_q;
    lnk_s lnk_d;

    logic sel_act;
    logic sel_fall;
    logic sel_rise;
    logic eoc_fall;
    logic stb_edge;
    logic link_rst;
    logic [2:0] strb_start;
    logic [2:0] link_start;

    // synchronised views; only stages 1 and 2 of each chain are read
    assign sel_act  = !sys_q.sel_p[1];
    assign sel_fall = sys_q.sel_p[2] && !sys_q.sel_p[1];
    assign sel_rise = !sys_q.sel_p[2] && sys_q.sel_p[1];
    assign eoc_fall = sys_q.eoc_p[2] && !sys_q.eoc_p[1];
    assign stb_edge = (sys_q.istb_p[1] ^ sys_q.istb_p[2])
                    || (sys_q.ostb_p[1] ^ sys_q.ostb_p[2]);
    assign link_rst = lnk_q.rst_p[1];

    // zero-base forces burst address 0, else the cpu start address
    assign strb_start = sys_q.zbt_lat ? ZERO_BASE : burst_start; // R21
    assign link_start = lnk_q.zbt_lat ? ZERO_BASE : lnk_q.start_p1; // R21

    // system-clock next state
    always_comb
    begin
        sys_d = sys_q;
        // chains keep shifting through reset so no false edge at release
        sys_d.sel_p  = {sys_q.sel_p[1:0], lnk.sel_n};
        sys_d.mode_p = {sys_q.mode_p[1:0], lnk.mclk_pin};
        sys_d.eoc_p  = {sys_q.eoc_p[1:0], lnk.eoc_n};
        sys_d.zbt_p  = {sys_q.zbt_p[0], lnk.zbt_n};
        sys_d.istb_p = {sys_q.istb_p[1:0], lnk.istb};
        sys_d.ostb_p = {sys_q.ostb_p[1:0], lnk.ostb};

        if (rst)
        begin
            // strap: select pin high means four transfers a line
            sys_d.four    = sys_q.sel_p[1]; // R19 R23
            sys_d.clocked = 1'b0;
            sys_d.zbt_lat = 1'b0;
            sys_d.idx     = PTR_RST;
            sys_d.ptr     = PTR_RST;
        end
        else
        begin
            // any toggle on the mode pin after reset: clocked for good
            if (sys_q.mode_p[1] ^ sys_q.mode_p[2])
            begin
                sys_d.clocked = 1'b1; // R18
            end

            // strobed counter only while the mode pin stays static
            if (!sys_q.clocked) // R17
            begin
                // after reset the strap pin acts as buffer select
                if (!sel_act) // R20
                begin
                    // deselected: keep sampling zero-base, hold at start
                    sys_d.zbt_lat = !sys_q.zbt_p[1]; // R02 R14
                    sys_d.idx     = PTR_RST; // R03 R05
                end
                else if (sel_fall)
                begin
                    // zero-base seen before select went active is kept;
                    // a strobe edge arriving with select still counts
                    sys_d.idx = stb_edge ? burst_step(PTR_RST, sys_q.four)
                                         : PTR_RST; // R16
                end
                else if (eoc_fall)
                begin
                    // lets select stay active across transfers
                    sys_d.zbt_lat = !sys_q.zbt_p[1]; // R22
                    sys_d.idx     = PTR_RST; // R06
                end
                else if (stb_edge)
                begin
                    // both strobe edges count, qualified by select
                    sys_d.idx = burst_step(sys_q.idx, sys_q.four); // R04 R14
                end

                if (sel_rise)
                begin
                    sys_d.idx = PTR_RST; // R15
                end
            end
            else
            begin
                sys_d.idx = PTR_RST;
            end

            sys_d.ptr = burst_ptr(strb_start, sys_q.idx, sys_q.four);
        end
    end

    always_ff @(posedge clk)
    begin
        sys_q <= sys_d;
    end

    // link-clock next state; mclk only runs in clocked mode
    always_comb
    begin
        lnk_d = lnk_q;
        lnk_d.rst_p    = {lnk_q.rst_p[0], rst};
        lnk_d.four_p   = {lnk_q.four_p[0], sys_q.four};
        // start address is quasi-static while a transfer runs
        lnk_d.start_p0 = burst_start;
        lnk_d.start_p1 = lnk_q.start_p0;

        if (link_rst)
        begin
            lnk_d.zbt_lat = 1'b0;
            lnk_d.idx     = PTR_RST;
            lnk_d.ptr     = PTR_RST;
        end
        else
        begin
            // select is sampled on every rising edge of the memory clock
            if (lnk.sel_n) // R11
            begin
                lnk_d.zbt_lat = !lnk.zbt_n; // R02
                lnk_d.idx     = PTR_RST; // R03 R05
            end
            else if (!lnk.eoc_n)
            begin
                // zero-base taken with end-of-cycle for the next transfer
                lnk_d.zbt_lat = !lnk.zbt_n; // R22
                lnk_d.idx     = PTR_RST; // R06
            end
            else if (!lnk.brdy_n) // R01 R12
            begin
                lnk_d.idx = burst_step(lnk_q.idx, lnk_q.four_p[1]); // R04
            end

            lnk_d.ptr = burst_ptr(link_start, lnk_q.idx, lnk_q.four_p[1]);
        end
    end

    always_ff @(posedge mclk)
    begin
        lnk_q <= lnk_d;
    end

    // outputs come straight from registers
    assign ptr_link     = lnk_q.ptr;
    assign ptr_strb     = sys_q.ptr;
    assign mode_clocked = sys_q.clocked;
    assign lines_four   = sys_q.four;

endmodule

/* sram_burst_ctl.sv */
/*
 * Memory bus controller end: makes the memory clock by dividing clk,
 * drives select, burst ready, zero-base, end-of-cycle and the input strobe; ostb is tied low.
 * Assumes a user that pulses start and abort on clk.
 */
`timescale 1ns/10ps
module sram_burst_ctl
    import sram_burst_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    burst_link.ctl    lnk,
    input  wire logic line_four,
    input  wire logic use_strobes,
    input  wire logic start,
    input  wire logic zero_base,
    input  wire logic abort,
    output logic      busy,
    output logic      done
);

    typedef struct packed {
        logic [3:0] div;
        logic       phase;
        logic       mclk;
        logic       strobed;
        logic       four;
        ctl_state_e state;
        logic [3:0] beat;
        logic       pend;
        logic       pend_zb;
        logic       pend_ab;
        logic       sel_n;
        logic       brdy_n;
        logic       zbt_n;
        logic       eoc_n;
        logic       istb;
        logic       busy;
        logic       done;
    } ctl_s;

    ctl_s q;
    ctl_s d;
    logic tick;
    logic act;
    logic [3:0] last;

    assign tick = (q.div == 4'(MCLK_HALF_CYC - 4'h1));
    // pins change on the falling half so they are stable at rising edges
    assign act  = tick && q.phase; // R13
    assign last = q.four ? BEATS_FOUR : BEATS_EIGHT;

    always_comb
    begin
        d      = q;
        d.done = 1'b0;
        d.div  = tick ? DIV_RST : 4'(q.div + 4'h1);
        d.phase = tick ? !q.phase : q.phase;
        // memory clock stays still in strobed mode
        d.mclk  = d.phase && !q.strobed;
        if (start)
        begin
            d.pend    = 1'b1;
            d.pend_zb = zero_base;
        end
        if (abort && q.state == C_XFER)
        begin
            d.pend_ab = 1'b1;
        end

        if (rst)
        begin
            d.div     = DIV_RST;
            d.phase   = 1'b0;
            d.mclk    = 1'b0;
            d.strobed = use_strobes;
            d.four    = line_four;
            d.state   = C_INIT;
            d.beat    = 4'h0;
            d.pend    = 1'b0;
            d.pend_zb = 1'b0;
            d.pend_ab = 1'b0;
            // strap on the shared select pin while reset is held
            d.sel_n   = line_four;
            d.brdy_n  = 1'b1;
            d.zbt_n   = 1'b1;
            d.eoc_n   = 1'b1;
            d.istb    = 1'b0;
            d.busy    = 1'b0;
        end
        else if (act)
        begin
            case (q.state)
                C_INIT:
                begin
                    d.sel_n = 1'b1; // R10
                    d.state = C_IDLE;
                end
                C_IDLE:
                begin
                    d.sel_n = 1'b1; // R07
                    d.eoc_n = 1'b1;
                    d.zbt_n = !q.pend_zb;
                    if (q.pend && q.zbt_n == !q.pend_zb)
                    begin
                        // select qualifies, so ready goes with it in clocked mode, a strobe edge in strobed mode
                        d.sel_n  = 1'b0; // R16
                        d.brdy_n = q.strobed;
                        d.istb   = q.strobed ? !q.istb : q.istb;
                        d.beat   = 4'h1;
                        d.pend   = start;
                        d.busy   = 1'b1;
                        d.state  = C_XFER;
                    end
                end
                C_XFER:
                begin
                    if (q.pend_ab)
                    begin
                        // restart the counter for the snoop writeback
                        d.sel_n   = 1'b1; // R09
                        d.brdy_n  = 1'b1;
                        d.pend_ab = 1'b0;
                        d.busy    = 1'b0;
                        d.state   = C_IDLE;
                    end
                    else if (q.beat == last)
                    begin
                        d.brdy_n = 1'b1;
                        d.eoc_n  = 1'b0;
                        d.state  = C_EOC;
                    end
                    else
                    begin
                        d.beat = 4'(q.beat + 4'h1);
                        d.istb = q.strobed ? !q.istb : q.istb;
                    end
                end
                C_EOC:
                begin
                    // deselect so the next transfer starts clean
                    d.sel_n = 1'b1; // R08
                    d.eoc_n = 1'b1;
                    d.busy  = 1'b0;
                    d.done  = 1'b1;
                    // an abort caught on the last beat must not hit the next
                    d.pend_ab = 1'b0;
                    d.state = C_IDLE;
                end
                default:
                begin
                    d.state = C_INIT;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        q <= d;
    end

    assign lnk.sel_n    = q.sel_n;
    assign lnk.brdy_n   = q.brdy_n;
    assign lnk.zbt_n    = q.zbt_n;
    assign lnk.eoc_n    = q.eoc_n;
    assign lnk.istb     = q.istb;
    assign lnk.ostb     = 1'b0;
    assign lnk.mclk_pin = q.mclk;
    assign busy         = q.busy;
    assign done         = q.done;

endmodule

/* burst_link_checker.sv */
/*
 * Checker for the controller-driven pins of the burst link.
 * Assumes clk and rst are the controller's clock and reset.
 */
`timescale 1ns/10ps
module burst_link_checker
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sel_n,
    input wire logic brdy_n,
    input wire logic zbt_n,
    input wire logic eoc_n,
    input wire logic istb,
    input wire logic ostb,
    input wire logic mclk_pin
);
    // one domain: every pin but the tied-low ostb is launched from clk registers
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_brdy_sel;
        !brdy_n |-> !sel_n;
    endproperty
    a_brdy_sel: assert property (p_brdy_sel)
        else $error("ready seen without select");

    property p_eoc_sel;
        !eoc_n |-> !sel_n;
    endproperty
    a_eoc_sel: assert property (p_eoc_sel)
        else $error("end of cycle seen without select");

    property p_eoc_after_beats;
        $rose(brdy_n) && !sel_n |-> !eoc_n;
    endproperty
    a_eoc_after_beats: assert property (p_eoc_after_beats)
        else $error("last beat not closed by end of cycle");

    property p_eoc_desel;
        $fell(eoc_n) |-> ##[1:24] ($rose(sel_n) && $rose(eoc_n));
    endproperty
    a_eoc_desel: assert property (p_eoc_desel)
        else $error("no deselect after end of cycle");

    // pins move only with the memory clock low, so rising edges see them
    property p_sel_mclk;
        mclk_pin |-> $stable(sel_n) && $stable(brdy_n) && $stable(eoc_n)
            && $stable(zbt_n);
    endproperty
    a_sel_mclk: assert property (p_sel_mclk)
        else $error("link pin moved while memory clock high");

    property p_mclk_high;
        $rose(mclk_pin) |=> mclk_pin [*5] ##1 !mclk_pin;
    endproperty
    a_mclk_high: assert property (p_mclk_high)
        else $error("memory clock high phase not six cycles");

    property p_mclk_low;
        $fell(mclk_pin) |=> !mclk_pin [*5] ##1 mclk_pin;
    endproperty
    a_mclk_low: assert property (p_mclk_low)
        else $error("memory clock low phase not six cycles");

    property p_after_reset;
        $fell(rst) |-> ##[0:16] sel_n [*6];
    endproperty
    a_after_reset: assert property (p_after_reset)
        else $error("select not held off after reset");

    property p_strobe_sel;
        $changed(istb) || $changed(ostb) |-> !sel_n;
    endproperty
    a_strobe_sel: assert property (p_strobe_sel)
        else $error("strobe moved without select");

    // zero-base may only move while the buffer is deselected
    property p_zbt_sel;
        $changed(zbt_n) |-> sel_n;
    endproperty
    a_zbt_sel: assert property (p_zbt_sel)
        else $error("zero-base moved while selected");
endmodule

/* tb_top.sv */
/*
 * Bench: controller and burst counter joined by one link, both modes.
 * Assumes the package functions are not used for expectations.
 */
`timescale 1ns/10ps
module tb_top;
    import sram_burst_pkg::*;
    logic       clk;
    logic       rst;
    logic       line_four;
    logic       use_strobes;
    logic       start;
    logic       zero_base;
    logic       abort;
    logic [2:0] burst_start;
    logic       busy;
    logic       done;
    logic [2:0] ptr_link;
    logic [2:0] ptr_strb;
    logic       mode_clocked;
    logic       lines_four;
    logic [2:0] cur_ptr;
    logic [2:0] seen[$];
    bit         rec;
    int         done_cnt = 0;
    int         n_mismatch;
    int         checks_done;

    burst_link burst_link_inst();
    sram_burst_ctl sram_burst_ctl_inst(.clk(clk), .rst(rst),
        .lnk(burst_link_inst.ctl), .line_four(line_four),
        .use_strobes(use_strobes), .start(start), .zero_base(zero_base),
        .abort(abort), .busy(busy), .done(done));
    sram_burst_dev sram_burst_dev_inst(.clk(clk), .rst(rst),
        .mclk(burst_link_inst.mclk_pin), .lnk(burst_link_inst.dev),
        .burst_start(burst_start), .ptr_link(ptr_link),
        .ptr_strb(ptr_strb), .mode_clocked(mode_clocked),
        .lines_four(lines_four));
    burst_link_checker burst_link_checker_inst(.clk(clk), .rst(rst),
        .sel_n(burst_link_inst.sel_n), .brdy_n(burst_link_inst.brdy_n),
        .zbt_n(burst_link_inst.zbt_n), .eoc_n(burst_link_inst.eoc_n),
        .istb(burst_link_inst.istb), .ostb(burst_link_inst.ostb),
        .mclk_pin(burst_link_inst.mclk_pin));

    // pointer of the mode under test
    assign cur_ptr = use_strobes ? ptr_strb : ptr_link;

    // 200 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // log done pulses and each new pointer value of a watched burst
    always @(posedge clk)
    begin
        if (done === 1'b1)
            done_cnt++;
        if (rec && (seen.size() == 0 || cur_ptr !== seen[$]))
            seen.push_back(cur_ptr);
    end

    task automatic compare(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got 0x%0h exp 0x%0h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // bounded wait for the next done pulse; a hang ends the run
    task automatic wait_done();
        int n0;
        n0 = done_cnt;
        for (int i = 0; i < 3000; i++)
        begin
            @(negedge clk);
            if (done_cnt != n0)
                return;
        end
        n_mismatch++;
        $display("Error at %0t: got 0x0 exp 0x1 (done)", $time);
        tally_and_finish();
    endtask

    // strap and mode are taken while reset is held
    task automatic t_config(input logic four, input logic strobes);
        @(negedge clk);
        rst = 1'b1;
        line_four = four;
        use_strobes = strobes;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (40) @(negedge clk);
        compare({7'h00, lines_four}, {7'h00, four});
        compare({7'h00, mode_clocked}, {7'h00, !strobes});
        $display("config test four=%0d strobes=%0d done", four, strobes);
    endtask

    // one whole line; the last pointers must walk the burst order
    task automatic t_burst(input logic zb, input logic four);
        logic [2:0] mask;
        logic [2:0] s;
        int         n;
        mask = four ? MASK_FOUR : MASK_EIGHT;
        n = four ? int'(BEATS_FOUR) : int'(BEATS_EIGHT);
        s = zb ? ZERO_BASE : (burst_start & mask);
        seen.delete();
        @(negedge clk);
        zero_base = zb;
        start = 1'b1;
        rec = 1'b1;
        @(negedge clk);
        start = 1'b0;
        wait_done();
        rec = 1'b0;
        if (seen.size() < n)
            compare(8'(seen.size()), 8'(n));
        else
            for (int k = 0; k < n; k++)
                compare({5'h00, seen[seen.size() - n + k]},
                    {5'h00, (s ^ 3'((k + 1) % n)) & mask});
        $display("burst test zb=%0d four=%0d done", zb, four);
    endtask

    // abort in mid-line: no done, and the next line starts afresh
    task automatic t_abort();
        int n0;
        t_config(1'b0, 1'b0);
        n0 = done_cnt;
        @(negedge clk);
        zero_base = 1'b0;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (40) @(negedge clk);
        abort = 1'b1;
        @(negedge clk);
        abort = 1'b0;
        repeat (30) @(negedge clk);
        compare({7'h00, busy}, 8'h00);
        compare(8'(done_cnt - n0), 8'h00);
        t_burst(1'b0, 1'b0);
        $display("abort test done");
    endtask

    // main sequence: every mode and line length, then an abort
    initial
    begin
        rst = 1'b1;
        line_four = 1'b0;
        use_strobes = 1'b0;
        start = 1'b0;
        zero_base = 1'b0;
        abort = 1'b0;
        burst_start = 3'h5;
        rec = 1'b0;
        n_mismatch = 0;
        checks_done = 0;
        for (int m = 0; m < 4; m++)
        begin
            t_config(m[0], m[1]);
            t_burst(1'b0, m[0]);
            t_burst(1'b1, m[0]);
        end
        t_abort();
        tally_and_finish();
    end
endmodule
